// ---- include/loop_ctrl_map.svh ----
// register offsets, field positions, reset values and timing counts for the loop mode control block
`ifndef LOOP_CTRL_MAP_SVH
`define LOOP_CTRL_MAP_SVH
// register indexes: the bus byte address is four times the index
`define HW_CTRL_SEL_OFS 8'h01
`define PRI_CTRL_ZERO_OFS 8'h1d
`define PRI_MODE_SEL_OFS 8'h1f
`define PRI_REF_SEL_OFS 8'h20
`define PRI_CAP_RANGE_OFS 8'h29
`define SEC_MODE_SEL_OFS 8'h2c
`define LOOP_STATUS_OFS 8'h30
`define REF_QUAL_OFS 8'h34
`define MODE_PIN_CTRL_BIT 0
`define BW_LSB 1
`define BW_MSB 3
`define EXT_BW_LSB 6
`define EXT_BW_MSB 7
`define CTRL_ZERO_RST 8'hc0
`define SEC_MODE_RST 8'h02
`define CAP_RANGE_RST 8'h00
`define ACQ_TIME_NS 1000
`define CLK_PERIOD_NS 50
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- include/loop_ctrl_pkg.sv ----
// types for the loop mode control block
package loop_ctrl_pkg;
  typedef enum logic [1:0] {
    MODE_MAN_NORMAL = 2'b00,
    MODE_MAN_HOLD = 2'b01,
    MODE_MAN_FREE = 2'b10,
    MODE_AUTO = 2'b11
  } mode_code_e;
  typedef enum logic [1:0] {
    ST_FREE = 2'b00,
    ST_ACQ = 2'b01,
    ST_NORMAL = 2'b10,
    ST_HOLD = 2'b11
  } loop_state_e;
  typedef struct packed {
    logic [2:0] bw;
    logic [1:0] extBw;
    logic [1:0] capRange;
  } loop_cfg_s;
  typedef struct packed {
    loop_state_e state;
    logic [2:0] refIdx;
    logic synced;
  } loop_stat_s;
endpackage : loop_ctrl_pkg

// ---- design/loop_mode_ctrl.sv ----
// mode control and loop configuration for the primary and secondary loops, AHB-Lite slave
`timescale 1ns/10ps
`include "loop_ctrl_map.svh"
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module loop_mode_ctrl
  import loop_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] modeStrapPins,
  input wire logic [7:0] refQualified,
  output loop_stat_s primaryStatus,
  output loop_stat_s secondaryStatus,
  output loop_cfg_s primaryCfg,
  output logic [3:0] primaryBwCode,
  output logic [3:0] secondaryBwCode,
  output logic [1:0] secondaryRangeCode,
  output logic primaryHoldover,
  output logic primaryLocked
);

  // ----------------------------------------------------------------------------
  // bandwidth encodings driven to the loop filter
  // ----------------------------------------------------------------------------
  localparam logic [3:0] BW_0P1HZ = 4'h0;
  localparam logic [3:0] BW_1P7HZ = 4'h1;
  localparam logic [3:0] BW_3P5HZ = 4'h2;
  localparam logic [3:0] BW_WIDE = 4'h5;
  localparam logic [3:0] BW_7HZ = 4'h6;
  localparam logic [3:0] BW_0P3MHZ = 4'h8;
  localparam logic [3:0] BW_1MHZ = 4'h9;
  localparam logic [3:0] BW_3MHZ = 4'ha;
  localparam logic [3:0] BW_14HZ = 4'hb;
  localparam logic [1:0] RANGE_130PPM = 2'b10;
  localparam int ACQ_CYC = `ACQ_CYCLES;

  // ----------------------------------------------------------------------------
  // ahb address phase capture
  // ----------------------------------------------------------------------------
  logic wrPend_q;
  logic [7:0] addr_q;
  logic takeAddr;
  assign takeAddr = hsel && hready && htrans[1];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wrPend_q <= takeAddr && hwrite;
      if (takeAddr) begin
        // word index: offsets are not all aligned, so byte address is four times the index
        addr_q <= haddr[9:2];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      // zero wait states once out of reset; response always okay
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  logic [7:0] hwCtrl_q;
  logic [7:0] ctrlZero_q;
  logic [7:0] priMode_q;
  logic [7:0] priRef_q;
  logic [7:0] capRange_q;
  logic [7:0] secMode_q;
  logic strapDone_q;
  logic [7:0] wd;
  logic [2:0] newBw;
  logic [1:0] newExt;
  assign wd = hwdata[7:0];
  assign newBw = wd[`BW_MSB:`BW_LSB];
  assign newExt = wd[`EXT_BW_MSB:`EXT_BW_LSB];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hwCtrl_q <= 8'h00;
      ctrlZero_q <= `CTRL_ZERO_RST;
      priRef_q <= 8'h00;
      capRange_q <= `CAP_RANGE_RST;
      secMode_q <= `SEC_MODE_RST;
    end else if (wrPend_q) begin
      if (addr_q == `HW_CTRL_SEL_OFS) begin
        hwCtrl_q <= wd;
      end else if (addr_q == `PRI_CTRL_ZERO_OFS) begin
        // reserved bandwidth codes keep the previous field
        ctrlZero_q[0] <= wd[0];
        ctrlZero_q[5:4] <= wd[5:4];
        if (newBw != 3'b011 && newBw != 3'b100) begin
          ctrlZero_q[`BW_MSB:`BW_LSB] <= newBw;
        end
        if (newExt != 2'b11) begin
          ctrlZero_q[`EXT_BW_MSB:`EXT_BW_LSB] <= newExt;
        end
      end else if (addr_q == `PRI_REF_SEL_OFS) begin
        priRef_q <= {5'h00, wd[2:0]};
      end else if (addr_q == `PRI_CAP_RANGE_OFS) begin
        capRange_q <= {6'h00, wd[1:0]};
      end else if (addr_q == `SEC_MODE_SEL_OFS) begin
        secMode_q <= {6'h00, wd[1:0]};
      end
    end
  end

  // straps are caught by the first clock after release, not by the async reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      priMode_q <= 8'h03;
      strapDone_q <= 1'b0;
    end else begin
      strapDone_q <= 1'b1;
      if (!strapDone_q) begin
        priMode_q <= {6'h00, modeStrapPins};
      end else if (wrPend_q && addr_q == `PRI_MODE_SEL_OFS) begin
        priMode_q <= {6'h00, wd[1:0]};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // mode selection and loop state machines
  // ----------------------------------------------------------------------------
  mode_code_e priModeSel;
  mode_code_e secModeSel;
  always_comb begin
    if (hwCtrl_q[`MODE_PIN_CTRL_BIT] && strapDone_q) begin
      priModeSel = mode_code_e'(modeStrapPins);
    end else begin
      priModeSel = mode_code_e'(priMode_q[1:0]);
    end
    secModeSel = mode_code_e'(secMode_q[1:0]);
  end

  // highest priority qualified reference: lowest index wins
  function automatic logic [3:0] pickRef(input logic [7:0] q);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (q[i]) begin
        r = {1'b0, 3'(i)};
      end
    end
    return r;
  endfunction : pickRef

  loop_stat_s st_q [2];
  logic [15:0] acqCnt_q [2];
  logic [1:0] stable;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gLoop
      mode_code_e m;
      logic [3:0] best;
      logic [2:0] manRef;
      logic curOk;
      assign m = (g == 0) ? priModeSel : secModeSel;
      assign manRef = (g == 0) ? priRef_q[2:0] : 3'h0;
      assign best = pickRef(refQualified);
      assign curOk = refQualified[st_q[g].refIdx];
      assign stable[g] = (acqCnt_q[g] >= 16'(ACQ_CYC - 1));

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          st_q[g] <= '{state: ST_FREE, refIdx: 3'h0, synced: 1'b0};
          acqCnt_q[g] <= 16'h0000;
        end else begin
          acqCnt_q[g] <= (st_q[g].state == ST_ACQ && curOk && !stable[g]) ? acqCnt_q[g] + 16'h0001 : 16'h0000;
          case (m)
            MODE_MAN_HOLD: begin
              st_q[g].state <= ST_HOLD;
            end
            MODE_MAN_FREE: begin
              st_q[g].state <= ST_FREE;
            end
            MODE_MAN_NORMAL: begin
              st_q[g].refIdx <= manRef;
              if (!refQualified[manRef]) begin
                st_q[g].state <= st_q[g].synced ? ST_HOLD : ST_FREE;
              end else if (st_q[g].state != ST_NORMAL && st_q[g].state != ST_ACQ) begin
                st_q[g].state <= ST_ACQ;
              end else if (st_q[g].state == ST_ACQ && stable[g]) begin
                st_q[g].state <= ST_NORMAL;
                st_q[g].synced <= 1'b1;
              end
            end
            default: begin
              case (st_q[g].state)
                ST_FREE, ST_HOLD: begin
                  if (!best[3]) begin
                    st_q[g].refIdx <= best[2:0];
                    st_q[g].state <= ST_ACQ;
                  end
                end
                ST_ACQ: begin
                  if (!curOk) begin
                    st_q[g].state <= st_q[g].synced ? ST_HOLD : ST_FREE;
                  end else if (stable[g]) begin
                    st_q[g].state <= ST_NORMAL;
                    st_q[g].synced <= 1'b1;
                  end
                end
                default: begin
                  if (!curOk && best[3]) begin
                    st_q[g].state <= ST_HOLD;
                  end else if (!curOk) begin
                    st_q[g].refIdx <= best[2:0];
                  end
                end
              endcase
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // bandwidth and range decode
  // ----------------------------------------------------------------------------
  logic [3:0] bwDecode;
  always_comb begin
    case (ctrlZero_q[`BW_MSB:`BW_LSB])
      3'b000: bwDecode = BW_0P1HZ;
      3'b001: bwDecode = BW_1P7HZ;
      3'b010: bwDecode = BW_3P5HZ;
      3'b101: bwDecode = BW_WIDE;
      3'b110: bwDecode = BW_7HZ;
      default: begin
        case (ctrlZero_q[`EXT_BW_MSB:`EXT_BW_LSB])
          2'b00: bwDecode = BW_0P3MHZ;
          2'b01: bwDecode = BW_1MHZ;
          default: bwDecode = BW_3MHZ;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      primaryStatus <= '0;
      secondaryStatus <= '0;
      primaryCfg <= '0;
      primaryBwCode <= BW_0P3MHZ;
      secondaryBwCode <= BW_14HZ;
      secondaryRangeCode <= RANGE_130PPM;
      primaryHoldover <= 1'b0;
      primaryLocked <= 1'b0;
    end else begin
      primaryStatus <= st_q[0];
      secondaryStatus <= st_q[1];
      primaryCfg <= '{bw: ctrlZero_q[3:1], extBw: ctrlZero_q[7:6], capRange: capRange_q[1:0]};
      primaryBwCode <= bwDecode;
      secondaryBwCode <= BW_14HZ;
      secondaryRangeCode <= RANGE_130PPM;
      primaryHoldover <= (st_q[0].state == ST_HOLD);
      primaryLocked <= (st_q[0].state == ST_NORMAL);
    end
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  // same word-index decode as the write side
  logic [7:0] rdIdx;
  assign rdIdx = haddr[9:2];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else if (takeAddr && !hwrite) begin
      if (rdIdx == `HW_CTRL_SEL_OFS) begin
        hrdata <= {24'h000000, hwCtrl_q};
      end else if (rdIdx == `PRI_CTRL_ZERO_OFS) begin
        hrdata <= {24'h000000, ctrlZero_q};
      end else if (rdIdx == `PRI_MODE_SEL_OFS) begin
        hrdata <= {24'h000000, priMode_q};
      end else if (rdIdx == `PRI_REF_SEL_OFS) begin
        hrdata <= {24'h000000, priRef_q};
      end else if (rdIdx == `PRI_CAP_RANGE_OFS) begin
        hrdata <= {24'h000000, capRange_q};
      end else if (rdIdx == `SEC_MODE_SEL_OFS) begin
        hrdata <= {24'h000000, secMode_q};
      end else if (rdIdx == `LOOP_STATUS_OFS) begin
        hrdata <= {16'h0000, 2'b00, st_q[1], 2'b00, st_q[0]};
      end else if (rdIdx == `REF_QUAL_OFS) begin
        hrdata <= {24'h000000, refQualified};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  logic curOkP;
  assign curOkP = refQualified[st_q[0].refIdx];

  AST_FREE_AFTER_RST: assert property (@(posedge clk) $fell(sys_rst) |-> st_q[0].state == ST_FREE)
    else $error("primary loop not free-run after reset");
  AST_MAN_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    priModeSel == MODE_MAN_HOLD |=> st_q[0].state == ST_HOLD)
    else $error("manual holdover not entered");
  AST_MAN_FREE: assert property (@(posedge clk) disable iff (sys_rst)
    priModeSel == MODE_MAN_FREE |=> st_q[0].state == ST_FREE)
    else $error("manual free-run not entered");
  AST_HOLD_ENTRY: assert property (@(posedge clk) disable iff (sys_rst)
    priModeSel == MODE_AUTO && st_q[0].state == ST_NORMAL && refQualified == 8'h00 |=> st_q[0].state == ST_HOLD)
    else $error("holdover not entered on loss");
  AST_SEC_BW: assert property (@(posedge clk) disable iff (sys_rst) secondaryBwCode == BW_14HZ)
    else $error("secondary bandwidth not fixed");
  AST_SEC_RANGE: assert property (@(posedge clk) disable iff (sys_rst) secondaryRangeCode == RANGE_130PPM)
    else $error("secondary range not fixed");
  AST_STRAP: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(strapDone_q) |-> priMode_q[1:0] == $past(modeStrapPins))
    else $error("strap not captured");
  AST_BW_WIDE: assert property (@(posedge clk) disable iff (sys_rst)
    ctrlZero_q[3:1] == 3'b101 |=> primaryBwCode == BW_WIDE)
    else $error("wideband code not decoded");
  AST_ACQ_NORMAL: assert property (@(posedge clk) disable iff (sys_rst)
    priModeSel == MODE_AUTO && st_q[0].state == ST_ACQ && stable[0] && curOkP |=> st_q[0].state == ST_NORMAL)
    else $error("acquisition did not reach normal");
  AST_MAN_NORMAL_FAIL: assert property (@(posedge clk) disable iff (sys_rst)
    priModeSel == MODE_MAN_NORMAL && !refQualified[priRef_q[2:0]] && st_q[0].synced |=> st_q[0].state == ST_HOLD)
    else $error("manual normal did not fall back to holdover");
  AST_AUTO_PICK: assert property (@(posedge clk) disable iff (sys_rst)
    priModeSel == MODE_AUTO && (st_q[0].state == ST_FREE || st_q[0].state == ST_HOLD) && refQualified != 8'h00
    |=> st_q[0].state == ST_ACQ)
    else $error("automatic mode did not start acquisition");

endmodule : loop_mode_ctrl

// ---- verif/ref_monitor_model.sv ----
// behavioural reference monitors feeding qualified flags to the loop control block
`timescale 1ns/10ps
module ref_monitor_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] refHealthy,
  input wire logic [3:0] qualDelay,
  output logic [7:0] refQualified
);
  logic [7:0] lastHealthy_q;
  logic [3:0] settle_q;
  // any change restarts settling; a failing input drops out at once, never late
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastHealthy_q <= 8'h00;
      settle_q <= 4'h0;
      refQualified <= 8'h00;
    end else begin
      lastHealthy_q <= refHealthy;
      if (refHealthy != lastHealthy_q) begin
        settle_q <= 4'h0;
      end else if (settle_q != 4'hf) begin
        settle_q <= settle_q + 4'h1;
      end
      if (settle_q >= qualDelay && refHealthy == lastHealthy_q) begin
        refQualified <= refHealthy;
      end else begin
        refQualified <= refQualified & refHealthy;
      end
    end
  end
endmodule : ref_monitor_model

// ---- verif/tb_top.sv ----
// self-checking bench for the loop mode control block
`timescale 1ns/10ps
`include "loop_ctrl_map.svh"
module tb_top import loop_ctrl_pkg::*;;
  logic clk, sysRst, hsel, hwrite, hreadyout, hresp, primaryHoldover, primaryLocked;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, straps, secondaryRangeCode;
  logic [2:0] hsize;
  logic [7:0] healthy, refQualified;
  logic [3:0] qualDelay, primaryBwCode, secondaryBwCode;
  loop_stat_s primaryStatus, secondaryStatus;
  loop_cfg_s primaryCfg;
  int failCount, samplesChecked;
  logic [7:0] bwWr [13] = '{8'h00, 8'h02, 8'h04, 8'h0a, 8'h0c, 8'h0e, 8'h4e, 8'h8e, 8'h02, 8'h06, 8'h08, 8'h4e, 8'hce};
  logic [3:0] bwExp [13] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'h1, 4'h1, 4'h1, 4'h9, 4'h9};

  loop_mode_ctrl DUT (.clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .modeStrapPins(straps), .refQualified(refQualified),
    .primaryStatus(primaryStatus), .secondaryStatus(secondaryStatus), .primaryCfg(primaryCfg),
    .primaryBwCode(primaryBwCode), .secondaryBwCode(secondaryBwCode),
    .secondaryRangeCode(secondaryRangeCode), .primaryHoldover(primaryHoldover),
    .primaryLocked(primaryLocked));

  ref_monitor_model monitors (.clk(clk), .sys_rst(sysRst), .refHealthy(healthy),
    .qualDelay(qualDelay), .refQualified(refQualified));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic finalReport;
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finalReport

  task automatic chk(input logic ok, input string msg);
    samplesChecked++;
    if (ok !== 1'b1) begin
      failCount++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  // one single transfer; master waits for hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    // a is the register index; byte address is four times it
    haddr <= {22'h000000, a, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    bus(1'b0, a, 8'h00);
    chk(rd === {24'h000000, exp} && hresp === 1'b0, msg);
  endtask : rdChk

  task automatic waitN(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitN

  task automatic setRefs(input logic [7:0] v);
    @(posedge clk);
    healthy <= v;
  endtask : setRefs

  // bounded wait for a loop state; sec selects the secondary loop
  task automatic waitSt(input logic sec, input loop_state_e s);
    int n;
    n = 0;
    while ((sec ? secondaryStatus.state : primaryStatus.state) !== s && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk((sec ? secondaryStatus.state : primaryStatus.state) === s, "loop state");
  endtask : waitSt

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    finalReport();
  end

  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    straps = 2'b11;
    healthy = 8'h00;
    qualDelay = 4'h1;
    failCount = 0;
    samplesChecked = 0;
    sysRst = 1'b1;
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    waitN(2);
    chk(primaryStatus.state === ST_FREE && secondaryStatus.state === ST_FREE, "free after reset");
    chk(secondaryBwCode === 4'hb && secondaryRangeCode === 2'b10, "secondary fixed");
    rdChk(`PRI_MODE_SEL_OFS, 8'h03, "strap default");
    rdChk(`SEC_MODE_SEL_OFS, 8'h02, "secondary default");
    rdChk(8'h50, 8'h00, "unmapped read");
    setRefs(8'h05);
    waitSt(1'b0, ST_ACQ);
    waitSt(1'b0, ST_NORMAL);
    chk(primaryStatus.refIdx === 3'h0 && primaryLocked === 1'b1, "top priority lock");
    setRefs(8'h04);
    waitN(3);
    waitSt(1'b0, ST_NORMAL);
    chk(primaryStatus.refIdx === 3'h2, "switch to next");
    setRefs(8'h00);
    waitSt(1'b0, ST_HOLD);
    chk(primaryHoldover === 1'b1 && primaryLocked === 1'b0, "holdover flag");
    setRefs(8'h02);
    waitSt(1'b0, ST_NORMAL);
    chk(primaryStatus.refIdx === 3'h1, "relock ref");
    rdChk(`REF_QUAL_OFS, 8'h02, "qualified mirror");
    rdChk(`LOOP_STATUS_OFS, 8'h23, "loop status");
    // manual modes, slower monitors
    qualDelay <= 4'h6;
    wr(`PRI_REF_SEL_OFS, 8'h03);
    wr(`PRI_MODE_SEL_OFS, 8'h00);
    setRefs(8'h0a);
    waitN(12);
    waitSt(1'b0, ST_NORMAL);
    chk(primaryStatus.refIdx === 3'h3, "manual ref");
    setRefs(8'h02);
    waitSt(1'b0, ST_HOLD);
    wr(`PRI_MODE_SEL_OFS, 8'h01);
    setRefs(8'h0a);
    waitN(40);
    chk(primaryStatus.state === ST_HOLD, "manual holdover");
    wr(`PRI_MODE_SEL_OFS, 8'h02);
    waitSt(1'b0, ST_FREE);
    waitN(40);
    chk(primaryStatus.state === ST_FREE, "manual free");
    // pin control
    wr(`HW_CTRL_SEL_OFS, 8'h01);
    waitSt(1'b0, ST_NORMAL);
    rdChk(`PRI_MODE_SEL_OFS, 8'h02, "mode reg kept");
    @(posedge clk);
    straps <= 2'b01;
    waitSt(1'b0, ST_HOLD);
    wr(`HW_CTRL_SEL_OFS, 8'h00);
    waitSt(1'b0, ST_FREE);
    // bandwidth codes, reserved ones last
    for (int i = 0; i < 13; i++) begin
      wr(`PRI_CTRL_ZERO_OFS, bwWr[i]);
      waitN(3);
      chk(primaryBwCode === bwExp[i], "bandwidth decode");
    end
    chk(primaryCfg.bw === 3'b111 && primaryCfg.extBw === 2'b01, "reserved kept");
    for (int i = 0; i < 4; i++) begin
      wr(`PRI_CAP_RANGE_OFS, 8'(i));
      waitN(2);
      chk(primaryCfg.capRange === 2'(i) && secondaryRangeCode === 2'b10, "capture range");
      rdChk(`PRI_CAP_RANGE_OFS, 8'(i), "capture readback");
    end
    // secondary loop by register only
    setRefs(8'h01);
    wr(`SEC_MODE_SEL_OFS, 8'h00);
    waitSt(1'b1, ST_NORMAL);
    chk(secondaryBwCode === 4'hb, "secondary bandwidth");
    // second reset with new straps
    @(posedge clk);
    straps <= 2'b00;
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    waitN(2);
    chk(primaryStatus.state === ST_FREE && secondaryStatus.state === ST_FREE, "free after reset");
    rdChk(`PRI_MODE_SEL_OFS, 8'h00, "strap resampled");
    finalReport();
  end
endmodule : tb_top
